//--- sim/hpq_host_port_chk.sv
// Purpose: Port-level assertions for the host port.
// Assumes: Strap is steady between resets.
// Notes: Indirect window bytes are tracked from the processor pins.
`timescale 1ns/1ns
module hpq_host_port_chk
    import hpq_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic BUS_STYLE_STRAP,
    input wire logic [9:0] ADDR,
    input wire logic [7:0] DATA_IN,
    input wire logic SEL_N,
    input wire logic DATA_OE,
    input wire logic INT_OUT,
    input wire logic READY_OUT,
    input wire logic [15:0] PORT_FLUSH_BITS,
    input wire logic FLUSH_DONE,
    input wire logic EXT_GO,
    input wire logic EXT_RD,
    input wire logic [23:0] EXT_ADDR,
    input wire logic [31:0] EXT_WDATA,
    input wire logic EXT_DONE
);
    logic [7:0] win_reg [8];
    logic [9:0] last_reg;
    always_ff @(posedge REF_CLK) begin
        if (!SEL_N) begin
            last_reg <= ADDR;
            if (ADDR[9:3] == 7'h26) win_reg[ADDR[2:0]] <= DATA_IN;
        end
    end
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);
    property p_go_pulse; EXT_GO |=> !EXT_GO; endproperty
    a_go_pulse: assert property (p_go_pulse) else $error("memory request longer than one cycle");
    property p_go_src; EXT_GO |-> (last_reg == 10'h133 || last_reg == 10'h137); endproperty
    a_go_src: assert property (p_go_src) else $error("memory request without trigger byte");
    property p_go_dir; EXT_GO |-> EXT_RD == (last_reg == 10'h133); endproperty
    a_go_dir: assert property (p_go_dir) else $error("memory request direction wrong");
    property p_go_addr; EXT_GO |-> EXT_ADDR == {win_reg[3], win_reg[2], win_reg[1]}; endproperty
    a_go_addr: assert property (p_go_addr) else $error("memory address bytes misordered");
    property p_go_data; EXT_GO && !EXT_RD |-> EXT_WDATA == {win_reg[4], win_reg[5], win_reg[6], win_reg[7]}; endproperty
    a_go_data: assert property (p_go_data) else $error("memory write data misordered");
    property p_wait; EXT_GO |=> (READY_OUT == BUS_STYLE_STRAP) until EXT_DONE; endproperty
    a_wait: assert property (p_wait) else $error("port ready during memory access");
    property p_flush_end; FLUSH_DONE && PORT_FLUSH_BITS != 16'h0000 |=> PORT_FLUSH_BITS == 16'h0000; endproperty
    a_flush_end: assert property (p_flush_end) else $error("flush bits kept after end");
    property p_flush_bound; $rose(|PORT_FLUSH_BITS) |-> ##[1:100] PORT_FLUSH_BITS == 16'h0000; endproperty
    a_flush_bound: assert property (p_flush_bound) else $error("flush never ended");
    property p_oe; DATA_OE |-> !$past(SEL_N, 1) || !$past(SEL_N, 2) || !$past(SEL_N, 3) || !$past(SEL_N, 4); endproperty
    a_oe: assert property (p_oe) else $error("data driven while not selected");
    property p_int_reset; $fell(RST) && !BUS_STYLE_STRAP |-> !INT_OUT; endproperty
    a_int_reset: assert property (p_int_reset) else $error("interrupt active after reset");
    c_ext_rd: cover property (EXT_GO && EXT_RD);
    c_ext_wr: cover property (EXT_GO && !EXT_RD);
    c_flush: cover property (FLUSH_DONE && PORT_FLUSH_BITS != 16'h0000);
endmodule
bind hpq_host_port hpq_host_port_chk i_hpq_host_port_chk (.REF_CLK(REF_CLK), .RST(RST),
    .BUS_STYLE_STRAP(BUS_STYLE_STRAP), .ADDR(ADDR), .DATA_IN(DATA_IN), .SEL_N(SEL_N), .DATA_OE(DATA_OE),
    .INT_OUT(INT_OUT), .READY_OUT(READY_OUT), .PORT_FLUSH_BITS(PORT_FLUSH_BITS), .FLUSH_DONE(FLUSH_DONE),
    .EXT_GO(EXT_GO), .EXT_RD(EXT_RD), .EXT_ADDR(EXT_ADDR), .EXT_WDATA(EXT_WDATA), .EXT_DONE(EXT_DONE));

//--- sim/hpq_ssram_model.sv
// Purpose: Behavioural cell memory on the far side of the indirect access engine.
// Assumes: One request at a time, taken on the edge where go is high.
// Notes: Answers after one to four cycles so that both prompt and slow replies occur.
`timescale 1ns/1ns
module hpq_ssram_model (
    input wire logic clk,
    input wire logic go,
    input wire logic rd,
    input wire logic [23:0] addr,
    input wire logic [31:0] wdata,
    output logic done,
    output logic [31:0] rdata
);
    logic [31:0] mem [int];
    int pseed = 77725;
    initial begin
        done = 1'b0;
        rdata = 32'h0000_0000;
    end
    always @(posedge clk) begin
        logic [23:0] a;
        logic [31:0] d;
        logic r;
        if (go) begin
            a = addr;
            d = wdata;
            r = rd;
            repeat (1 + ($random(pseed) & 3)) @(posedge clk);
            #1;
            if (!r) mem[a] = d;
            rdata = r ? (mem.exists(a) ? mem[a] : 32'h0000_0000) : ~rdata;
            done = 1'b1;
            @(posedge clk);
            #1;
            done = 1'b0;
            // Data is only good in the done cycle, so spoil it afterwards.
            rdata = ~rdata;
        end
    end
endmodule

//--- sim/test_host_port_queue_table_access.sv
// Purpose: Self-checking bench for the host port.
// Assumes: Slow bus cycles that outlast the pin synchronisers.
// Notes: Expected values come from the bench's own record of what it wrote.
`timescale 1ns/1ns
module test_host_port_queue_table_access;
    import hpq_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic strap = 1'b0;
    logic [9:0] addr = 10'h000;
    logic [7:0] din = 8'h00;
    logic sel_n = 1'b1;
    logic wr_n = 1'b1;
    logic rd_n = 1'b1;
    logic dsel = 1'b0;
    logic [7:0] ev_a = 8'h00;
    logic [7:0] ev_b = 8'h00;
    logic flush_done = 1'b0;
    logic [7:0] dout;
    logic int_out, ready, ext_go, ext_rd, ext_done;
    logic [15:0] inlet, flush;
    logic [31:0] act_lo, act_hi, ext_wdata, ext_rdata;
    logic [23:0] ext_addr;
    logic [7:0] rb;
    int n_mismatch = 0;
    int tests_run = 0;
    int seed = 77725;
    always #5 ref_clk = ~ref_clk;
    hpq_host_port #(.FLUSH_CYCLES(16)) i_hpq_host_port (.REF_CLK(ref_clk), .RST(rst), .CE(1'b1),
        .BUS_STYLE_STRAP(strap), .ADDR(addr), .DATA_IN(din), .DATA_OUT(dout), .DATA_OE(), .SEL_N(sel_n),
        .WR_N(wr_n), .RD_N(rd_n), .DIRECTION_SELECT(dsel), .INT_OUT(int_out), .READY_OUT(ready),
        .EVENT_A(ev_a), .EVENT_B(ev_b), .EVENT_C(8'h00), .INLET_PORT_ENABLE(inlet), .PORT_FLUSH_BITS(flush),
        .FLUSH_DONE(flush_done), .QUEUE_ACTIVE_LO(act_lo), .QUEUE_ACTIVE_HI(act_hi), .EXT_GO(ext_go),
        .EXT_RD(ext_rd), .EXT_ADDR(ext_addr), .EXT_WDATA(ext_wdata), .EXT_DONE(ext_done), .EXT_RDATA(ext_rdata));
    hpq_ssram_model i_hpq_ssram_model (.clk(ref_clk), .go(ext_go), .rd(ext_rd), .addr(ext_addr),
        .wdata(ext_wdata), .done(ext_done), .rdata(ext_rdata));
    task automatic complete_run;
        $display("tests_run %0d n_mismatch %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Holds the cycle until the port stops asking for wait time, then takes the read byte.
    task automatic bus(input logic rd, input logic [9:0] a, input logic [7:0] d);
        int k;
        @(posedge ref_clk);
        #1;
        addr = a;
        din = d;
        sel_n = 1'b0;
        wr_n = strap | rd;
        rd_n = ~rd;
        dsel = rd;
        repeat (6) @(posedge ref_clk);
        k = 0;
        while (ready === strap && k < 200) begin
            @(posedge ref_clk);
            k++;
        end
        if (k >= 200) n_mismatch++;
        rb = dout;
        #1;
        sel_n = 1'b1;
        wr_n = 1'b1;
        rd_n = 1'b1;
        repeat (4) @(posedge ref_clk);
        #1;
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        bus(1'b0, a, d);
    endtask
    task automatic rdc(input logic [9:0] a, input logic [7:0] exp, input string what);
        bus(1'b1, a, 8'h00);
        check(what, 32'(rb), 32'(exp));
    endtask
    task automatic qm(input logic [1:0] code, input logic [23:0] qa, input logic [31:0] qd);
        wr(10'h130, {6'h00, code});
        wr(10'h131, qa[7:0]);
        wr(10'h132, qa[15:8]);
        wr(10'h133, qa[23:16]);
        if (!code[0]) for (int i = 0; i < 4; i++) wr(10'h134 + 10'(i), qd[31 - 8 * i -: 8]);
        rdc(10'h106, 8'h08, "done flag");
    endtask
    task automatic rdword(input logic [31:0] exp);
        for (int i = 0; i < 4; i++) rdc(10'h134 + 10'(i), exp[31 - 8 * i -: 8], "word byte");
    endtask
    initial begin
        logic [9:0] offs [5];
        logic [7:0] v [5];
        logic [23:0] qa;
        logic [31:0] qd [4];
        offs = '{10'h006, 10'h009, 10'h107, 10'h102, 10'h103};
        repeat (5) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        repeat (6) @(posedge ref_clk);
        for (int i = 0; i < 5; i++) begin
            v[i] = 8'($random(seed));
            wr(offs[i], v[i]);
        end
        for (int i = 0; i < 5; i++) rdc(offs[i], v[i], "register");
        check("inlet enables", 32'(inlet), {16'h0000, v[4], v[3]});
        rdc(10'h3ff, 8'h00, "unmapped");
        wr(10'h006, 8'h00);
        ev_a = 8'h5a;
        repeat (4) @(posedge ref_clk);
        #1;
        ev_a = 8'h00;
        check("masked interrupt", 32'(int_out), 32'h0);
        wr(10'h006, 8'h42);
        check("interrupt", 32'(int_out), 32'h1);
        rdc(10'h005, 8'h5a, "status a");
        rdc(10'h005, 8'h00, "status a");
        check("interrupt", 32'(int_out), 32'h0);
        ev_b = 8'h80;
        rdc(10'h008, 8'h80, "status b");
        ev_b = 8'h00;
        rdc(10'h008, 8'h80, "status b");
        rdc(10'h008, 8'h00, "status b");
        $display("test events done");
        for (int q = 0; q < 4; q++) begin
            qd[q] = $random(seed);
            qm(2'b00, {17'h0, 4'h9, 2'(q), 1'(q)}, qd[q]);
        end
        for (int q = 0; q < 4; q++) begin
            qm(2'b01, {17'h0, 4'h9, 2'(q), 1'(q)}, 32'h0);
            rdword(qd[q]);
        end
        qd[0] = $random(seed);
        qd[1] = $random(seed);
        qm(2'b00, 24'h000100, qd[0]);
        qm(2'b00, 24'h000101, qd[1]);
        check("active low", act_lo, qd[0]);
        check("active high", act_hi, qd[1]);
        for (int i = 0; i < 2; i++) begin
            qa = 24'($random(seed));
            qd[i] = $random(seed);
            qm(2'b10, qa, qd[i]);
            qm(2'b11, qa, 32'h0);
            rdword(qd[i]);
        end
        $display("test indirect done");
        for (int j = 0; j < 2; j++) begin
            v[0] = 8'($random(seed)) | 8'h01;
            v[1] = 8'($random(seed));
            wr(10'h108, v[0]);
            wr(10'h109, v[1]);
            check("flush bits", 32'(flush), {16'h0000, v[1], v[0]});
            if (j == 1) begin
                flush_done = 1'b1;
                @(posedge ref_clk);
                #1;
                flush_done = 1'b0;
            end
            repeat (30) @(posedge ref_clk);
            check("flush bits", 32'(flush), 32'h0);
            rdc(10'h106, 8'h04, "deleted flag");
        end
        $display("test flush done");
        rst = 1'b1;
        strap = 1'b1;
        repeat (5) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        repeat (6) @(posedge ref_clk);
        check("idle interrupt", 32'(int_out), 32'h1);
        wr(10'h107, 8'h08);
        qm(2'b00, 24'h000001, 32'h0000_0001);
        ev_b = 8'h01;
        wr(10'h009, 8'h01);
        check("interrupt", 32'(int_out), 32'h0);
        $display("test direction style done");
        complete_run;
    end
    initial begin
        #300000;
        n_mismatch++;
        complete_run;
    end
endmodule

//--- src/hpq_consts.svh
// Purpose: Offsets, field positions, reset values and timing counts of the host port.
// Assumes: 10-bit byte addresses on the processor port.
// Notes: Included by the design modules.
`ifndef HPQ_CONSTS_SVH
`define HPQ_CONSTS_SVH
`define HPQ_OFF_STAT_A 10'h005
`define HPQ_OFF_EN_A 10'h006
`define HPQ_OFF_STAT_B 10'h008
`define HPQ_OFF_EN_B 10'h009
`define HPQ_OFF_INLET_LO 10'h102
`define HPQ_OFF_INLET_HI 10'h103
`define HPQ_OFF_STAT_C 10'h106
`define HPQ_OFF_EN_C 10'h107
`define HPQ_OFF_FLUSH_1 10'h108
`define HPQ_OFF_FLUSH_2 10'h109
`define HPQ_OFF_CTRL 10'h130
`define HPQ_OFF_ADDR0 10'h131
`define HPQ_OFF_ADDR1 10'h132
`define HPQ_OFF_ADDR2 10'h133
`define HPQ_OFF_DATA3 10'h134
`define HPQ_OFF_DATA2 10'h135
`define HPQ_OFF_DATA1 10'h136
`define HPQ_OFF_DATA0 10'h137
`define HPQ_CTRL_DIR_BIT 0
`define HPQ_CTRL_TGT_BIT 1
`define HPQ_STC_DONE_BIT 3
`define HPQ_STC_QDEL_BIT 2
`define HPQ_ACT_LO_ADDR 24'h000100
`define HPQ_ACT_HI_ADDR 24'h000101
`define HPQ_ENTRY_WORDS 128
`define HPQ_RESET_BYTE 8'h00
`define HPQ_FLUSH_CYCLES 16
`endif

//--- src/hpq_host_port.sv
// Purpose: Byte-wide processor port with status, flush and indirect access registers.
// Assumes: Processor pins are asynchronous to REF_CLK and are synchronised.
// Notes: One word access at a time; the port waits while the engine works.
`timescale 1ns/1ns
`include "hpq_consts.svh"
module hpq_host_port
    import hpq_pkg::*;
#(
    parameter int FLUSH_CYCLES = `HPQ_FLUSH_CYCLES
)
(
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic BUS_STYLE_STRAP,
    input wire logic [9:0] ADDR,
    input wire logic [7:0] DATA_IN,
    output logic [7:0] DATA_OUT,
    output logic DATA_OE,
    input wire logic SEL_N,
    input wire logic WR_N,
    input wire logic RD_N,
    input wire logic DIRECTION_SELECT,
    output logic INT_OUT,
    output logic READY_OUT,
    input wire logic [7:0] EVENT_A,
    input wire logic [7:0] EVENT_B,
    input wire logic [7:0] EVENT_C,
    output logic [15:0] INLET_PORT_ENABLE,
    output logic [15:0] PORT_FLUSH_BITS,
    input wire logic FLUSH_DONE,
    output logic [31:0] QUEUE_ACTIVE_LO,
    output logic [31:0] QUEUE_ACTIVE_HI,
    output logic EXT_GO,
    output logic EXT_RD,
    output logic [23:0] EXT_ADDR,
    output logic [31:0] EXT_WDATA,
    input wire logic EXT_DONE,
    input wire logic [31:0] EXT_RDATA
);
    logic [1:0] sel_s_reg, wr_s_reg, rd_s_reg, dir_s_reg, strap_s_reg;
    logic [9:0] addr_s1_reg, addr_s2_reg;
    logic [7:0] din_s1_reg, din_s2_reg;
    logic style_reg, strap_seen_reg;
    logic act_prev_reg, busy_reg;
    logic [7:0] stat_a_reg, stat_b_reg, stat_c_reg, en_a_reg, en_b_reg, en_c_reg;
    logic [7:0] ctrl_reg;
    logic [23:0] indirect_address;
    logic [31:0] indirect_data;
    logic [15:0] flush_reg;
    logic flush_armed_reg;
    logic [$clog2(FLUSH_CYCLES+1)-1:0] flush_cnt_reg;
    logic [15:0] inlet_reg;
    logic [1:0] word_idx_reg;
    logic [31:0] word_cache_reg;
    logic cyc_active, cyc_write, cyc_start;
    logic [9:0] a;
    logic [7:0] d;
    hpq_req_t req;
    hpq_rsp_t rsp;
    logic irq;

    // Synchronisers: first stage is read only by the second.
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            sel_s_reg <= 2'h3;
            wr_s_reg <= 2'h3;
            rd_s_reg <= 2'h3;
            dir_s_reg <= 2'h3;
            addr_s1_reg <= 10'h000;
            addr_s2_reg <= 10'h000;
            din_s1_reg <= 8'h00;
            din_s2_reg <= 8'h00;
        end else if (CE) begin
            sel_s_reg <= {sel_s_reg[0], SEL_N};
            wr_s_reg <= {wr_s_reg[0], WR_N};
            rd_s_reg <= {rd_s_reg[0], RD_N};
            dir_s_reg <= {dir_s_reg[0], DIRECTION_SELECT};
            addr_s1_reg <= ADDR;
            addr_s2_reg <= addr_s1_reg;
            din_s1_reg <= DATA_IN;
            din_s2_reg <= din_s1_reg;
        end
    end

    // The strap chain runs through reset, so the catch below never sees a cleared stage.
    always_ff @(posedge REF_CLK) begin
        if (CE) begin
            strap_s_reg <= {strap_s_reg[0], BUS_STYLE_STRAP};
        end
    end

    // The strap is caught once, after reset release, once synchronised.
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            style_reg <= 1'b0;
            strap_seen_reg <= 1'b0;
        end else if (CE && !strap_seen_reg) begin
            style_reg <= strap_s_reg[1];
            strap_seen_reg <= 1'b1;
        end
    end

    assign a = addr_s2_reg;
    assign d = din_s2_reg;
    // Strobe style uses two strobes; direction style reads the direction line.
    assign cyc_active = !sel_s_reg[1] && (style_reg ? 1'b1 : (!wr_s_reg[1] || !rd_s_reg[1]));
    assign cyc_write = style_reg ? !dir_s_reg[1] : !wr_s_reg[1];
    assign cyc_start = cyc_active && !act_prev_reg;

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            act_prev_reg <= 1'b0;
        end else if (CE) begin
            act_prev_reg <= cyc_active;
        end
    end

    // Engine request is launched on the starting edge of the trigger byte.
    always_comb begin
        req = '0;
        req.addr = indirect_address;
        req.data = {indirect_data[31:8], d};
        req.to_ssram = ctrl_reg[`HPQ_CTRL_TGT_BIT];
        req.rd = ctrl_reg[`HPQ_CTRL_DIR_BIT];
        if (cyc_start && cyc_write) begin
            if (a == `HPQ_OFF_DATA0 && !req.rd) begin
                req.go = 1'b1;
            end
            if (a == `HPQ_OFF_ADDR2 && req.rd) begin
                req.addr = {d, indirect_address[15:0]};
                req.go = 1'b1;
            end
        end
    end

    hpq_table_engine u_engine (
        .clk(REF_CLK),
        .rst(RST),
        .ce(CE),
        .req(req),
        .rsp(rsp),
        .active_lo(QUEUE_ACTIVE_LO),
        .active_hi(QUEUE_ACTIVE_HI),
        .ext_go(EXT_GO),
        .ext_rd(EXT_RD),
        .ext_addr(EXT_ADDR),
        .ext_wdata(EXT_WDATA),
        .ext_done(EXT_DONE),
        .ext_rdata(EXT_RDATA)
    );

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            busy_reg <= 1'b0;
        end else if (CE) begin
            if (req.go) begin
                busy_reg <= 1'b1;
            end else if (rsp.done) begin
                busy_reg <= 1'b0;
            end
        end
    end

    // Control, address and data byte registers; least significant data byte highest, least significant address byte lowest.
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            ctrl_reg <= `HPQ_RESET_BYTE;
            indirect_address <= 24'h000000;
            indirect_data <= 32'h00000000;
            en_a_reg <= `HPQ_RESET_BYTE;
            en_b_reg <= `HPQ_RESET_BYTE;
            en_c_reg <= `HPQ_RESET_BYTE;
            inlet_reg <= 16'h0000;
        end else if (CE) begin
            if (rsp.done && busy_reg && ctrl_reg[`HPQ_CTRL_DIR_BIT]) begin
                indirect_data <= rsp.data;
            end else if (cyc_start && cyc_write) begin
                case (a)
                    `HPQ_OFF_CTRL: ctrl_reg <= d;
                    `HPQ_OFF_ADDR0: indirect_address[7:0] <= d;
                    `HPQ_OFF_ADDR1: indirect_address[15:8] <= d;
                    `HPQ_OFF_ADDR2: indirect_address[23:16] <= d;
                    `HPQ_OFF_DATA3: indirect_data[31:24] <= d;
                    `HPQ_OFF_DATA2: indirect_data[23:16] <= d;
                    `HPQ_OFF_DATA1: indirect_data[15:8] <= d;
                    `HPQ_OFF_DATA0: indirect_data[7:0] <= d;
                    `HPQ_OFF_EN_A: en_a_reg <= d;
                    `HPQ_OFF_EN_B: en_b_reg <= d;
                    `HPQ_OFF_EN_C: en_c_reg <= d;
                    `HPQ_OFF_INLET_LO: inlet_reg[7:0] <= d;
                    `HPQ_OFF_INLET_HI: inlet_reg[15:8] <= d;
                    default: ;
                endcase
            end
        end
    end

    // Word window: byte 3 snapshots the word, byte 0 read closes the access.
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            word_idx_reg <= 2'h0;
            word_cache_reg <= 32'h00000000;
        end else if (CE && cyc_start && a >= `HPQ_OFF_DATA3 && a <= `HPQ_OFF_DATA0) begin
            if (a == `HPQ_OFF_DATA3) begin
                word_cache_reg <= indirect_data;
                word_idx_reg <= 2'h1;
            end else if (a == `HPQ_OFF_DATA0 && !cyc_write) begin
                word_idx_reg <= 2'h0;
            end else begin
                word_idx_reg <= word_idx_reg + 2'h1;
            end
        end
    end

    // Flush starts only after 109H follows 108H; completion clears the set bits.
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            flush_reg <= 16'h0000;
            flush_armed_reg <= 1'b0;
            flush_cnt_reg <= '0;
        end else if (CE) begin
            if (cyc_start && cyc_write && a == `HPQ_OFF_FLUSH_1) begin
                flush_reg[7:0] <= d;
                flush_armed_reg <= 1'b1;
            end else if (cyc_start && cyc_write && a == `HPQ_OFF_FLUSH_2 && flush_armed_reg) begin
                flush_reg[15:8] <= d;
                flush_armed_reg <= 1'b0;
                flush_cnt_reg <= ($clog2(FLUSH_CYCLES+1))'(FLUSH_CYCLES);
            end else if (flush_cnt_reg != '0) begin
                if (FLUSH_DONE || flush_cnt_reg == 1) begin
                    flush_cnt_reg <= '0;
                    flush_reg <= 16'h0000;
                end else begin
                    flush_cnt_reg <= flush_cnt_reg - 1'b1;
                end
            end
        end
    end

    function automatic logic [7:0] clr_on_read(input logic [7:0] st, input logic [7:0] ev,
                                               input logic rd_hit);
        clr_on_read = (rd_hit ? 8'h00 : st) | ev;
    endfunction

    logic rd_pulse, flush_end;
    logic [7:0] ev_c;
    assign rd_pulse = cyc_start && !cyc_write;
    assign flush_end = CE && flush_cnt_reg != '0 && (FLUSH_DONE || flush_cnt_reg == 1);
    always_comb begin
        ev_c = EVENT_C;
        ev_c[`HPQ_STC_DONE_BIT] = rsp.done;
        ev_c[`HPQ_STC_QDEL_BIT] = flush_end;
    end

    // Set wins over the clear of a read in the same cycle.
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            stat_a_reg <= 8'h00;
            stat_b_reg <= 8'h00;
            stat_c_reg <= 8'h00;
        end else if (CE) begin
            stat_a_reg <= clr_on_read(stat_a_reg, EVENT_A, rd_pulse && a == `HPQ_OFF_STAT_A);
            stat_b_reg <= clr_on_read(stat_b_reg, EVENT_B, rd_pulse && a == `HPQ_OFF_STAT_B);
            stat_c_reg <= clr_on_read(stat_c_reg, ev_c, rd_pulse && a == `HPQ_OFF_STAT_C);
        end
    end

    assign irq = |(stat_a_reg & en_a_reg) | |(stat_b_reg & en_b_reg) | |(stat_c_reg & en_c_reg);

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            DATA_OUT <= 8'h00;
        end else if (CE && cyc_start && !cyc_write) begin
            case (a)
                `HPQ_OFF_STAT_A: DATA_OUT <= stat_a_reg;
                `HPQ_OFF_EN_A: DATA_OUT <= en_a_reg;
                `HPQ_OFF_STAT_B: DATA_OUT <= stat_b_reg;
                `HPQ_OFF_EN_B: DATA_OUT <= en_b_reg;
                `HPQ_OFF_INLET_LO: DATA_OUT <= inlet_reg[7:0];
                `HPQ_OFF_INLET_HI: DATA_OUT <= inlet_reg[15:8];
                `HPQ_OFF_STAT_C: DATA_OUT <= stat_c_reg;
                `HPQ_OFF_EN_C: DATA_OUT <= en_c_reg;
                `HPQ_OFF_FLUSH_1: DATA_OUT <= flush_reg[7:0];
                `HPQ_OFF_FLUSH_2: DATA_OUT <= flush_reg[15:8];
                `HPQ_OFF_CTRL: DATA_OUT <= ctrl_reg;
                `HPQ_OFF_ADDR0: DATA_OUT <= indirect_address[7:0];
                `HPQ_OFF_ADDR1: DATA_OUT <= indirect_address[15:8];
                `HPQ_OFF_ADDR2: DATA_OUT <= indirect_address[23:16];
                `HPQ_OFF_DATA3: DATA_OUT <= indirect_data[31:24];
                `HPQ_OFF_DATA2: DATA_OUT <= word_cache_reg[23:16];
                `HPQ_OFF_DATA1: DATA_OUT <= word_cache_reg[15:8];
                `HPQ_OFF_DATA0: DATA_OUT <= word_cache_reg[7:0];
                default: DATA_OUT <= 8'h00;
            endcase
        end
    end

    assign DATA_OE = cyc_active && !cyc_write && act_prev_reg;
    assign INT_OUT = style_reg ? !irq : irq;
    // Ready drops while the engine is busy or a request launches; direction style inverts it and also waits while no cycle is seen.
    assign READY_OUT = style_reg ? (busy_reg || req.go || !act_prev_reg) : !(busy_reg || req.go);
    assign INLET_PORT_ENABLE = inlet_reg;
    assign PORT_FLUSH_BITS = flush_reg;
endmodule

//--- src/hpq_pkg.sv
// Purpose: Shared types of the host port.
// Assumes: Constants come from the companion header.
// Notes: Carriers travel as packed structs.
package hpq_pkg;
    typedef struct packed {
        logic [31:0] data;
        logic [23:0] addr;
        logic to_ssram;
        logic rd;
        logic go;
    } hpq_req_t;
    typedef struct packed {
        logic [31:0] data;
        logic done;
    } hpq_rsp_t;
    typedef enum logic [1:0] {HPQ_IDLE, HPQ_BUSY, HPQ_WAIT_EXT} hpq_state_t;
endpackage

//--- src/hpq_table_engine.sv
// Purpose: Queue pointer table, activity words and the indirect access engine.
// Assumes: External cell memory answers with a one-cycle done strobe.
// Notes: The table has no defined reset content; software must load it.
`timescale 1ns/1ns
`include "hpq_consts.svh"
module hpq_table_engine
    import hpq_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire hpq_req_t req,
    output hpq_rsp_t rsp,
    output logic [31:0] active_lo,
    output logic [31:0] active_hi,
    output logic ext_go,
    output logic ext_rd,
    output logic [23:0] ext_addr,
    output logic [31:0] ext_wdata,
    input wire logic ext_done,
    input wire logic [31:0] ext_rdata
);
    // Word 2n: write pointer in 31:14, read pointer 17:4 in 13:0.
    // Word 2n+1: read pointer 3:0, cell count 27:14, depth limit 13:0.
    logic [31:0] queue_pointer_table [0:`HPQ_ENTRY_WORDS-1];
    hpq_state_t state_reg;
    logic [23:0] addr_reg;

    function automatic logic is_act(input logic [23:0] a);
        is_act = (a == `HPQ_ACT_LO_ADDR) || (a == `HPQ_ACT_HI_ADDR);
    endfunction

    always_ff @(posedge clk) begin
        if (ce && req.go && !req.to_ssram && !req.rd && !is_act(req.addr)) begin
            queue_pointer_table[req.addr[6:0]] <= req.data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            active_lo <= 32'h00000000;
            active_hi <= 32'h00000000;
        end else if (ce && req.go && !req.to_ssram && !req.rd) begin
            if (req.addr == `HPQ_ACT_LO_ADDR) begin
                active_lo <= req.data;
            end
            if (req.addr == `HPQ_ACT_HI_ADDR) begin
                active_hi <= req.data;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= HPQ_IDLE;
            addr_reg <= 24'h000000;
            rsp <= '0;
            ext_go <= 1'b0;
            ext_rd <= 1'b0;
            ext_addr <= 24'h000000;
            ext_wdata <= 32'h00000000;
        end else if (ce) begin
            rsp.done <= 1'b0;
            ext_go <= 1'b0;
            case (state_reg)
                HPQ_IDLE: begin
                    if (req.go) begin
                        addr_reg <= req.addr;
                        if (req.to_ssram) begin
                            ext_go <= 1'b1;
                            ext_rd <= req.rd;
                            ext_addr <= req.addr;
                            ext_wdata <= req.data;
                            state_reg <= HPQ_WAIT_EXT;
                        end else begin
                            state_reg <= req.rd ? HPQ_BUSY : HPQ_IDLE;
                            rsp.done <= !req.rd;
                        end
                    end
                end
                HPQ_BUSY: begin
                    if (addr_reg == `HPQ_ACT_LO_ADDR) begin
                        rsp.data <= active_lo;
                    end else if (addr_reg == `HPQ_ACT_HI_ADDR) begin
                        rsp.data <= active_hi;
                    end else begin
                        rsp.data <= queue_pointer_table[addr_reg[6:0]];
                    end
                    rsp.done <= 1'b1;
                    state_reg <= HPQ_IDLE;
                end
                HPQ_WAIT_EXT: begin
                    if (ext_done) begin
                        rsp.data <= ext_rd ? ext_rdata : rsp.data;
                        rsp.done <= 1'b1;
                        state_reg <= HPQ_IDLE;
                    end
                end
                default: state_reg <= HPQ_IDLE;
            endcase
        end
    end
endmodule
